// ### hdl/utxch_ctrl_high.sv
// transmit endpoint upper control byte with toggle, dma and auto ready
// assumes fifo load, sent and ack strobes are one-cycle pulses on I_CLK
`timescale 1ns/1ps
`default_nettype none
module utxch_ctrl_high (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_NRST,
   // wishbone classic slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [11:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic O_WB_ACK,
   output logic [31:0] O_WB_DAT,
   // controller context
   input wire logic I_HOST_MODE,
   input wire logic I_SHARED_FIFO,
   // endpoint events
   input wire logic I_FIFO_LOAD,
   input wire logic I_TX_SENT,
   input wire logic I_TX_ACK,
   // endpoint controls
   output logic O_TOGGLE,
   output logic O_TX_READY,
   output logic O_FLUSH,
   output logic O_TX_DONE_EVT,
   output logic O_ISO,
   output logic O_DIR_TX,
   output logic O_DMA_REQ_EN,
   output logic O_DMA_MODE1,
   output logic O_DMA_REQ
);
   import utxch_pkg::*;
   // all checks run on the system clock and rest while reset is low
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic auto_ready;
      logic iso;
      logic dir;
      logic dma_en;
      logic dma_mode;
      logic toggle;
      logic ready;
      logic [PAYLOAD_W-1:0] cnt;
      logic [PAYLOAD_W-1:0] max_payload;
      logic flush;
      logic done_evt;
      logic dma_req;
      logic dir_tx;
   } utxch_state_t;

   utxch_state_t st_ff;
   utxch_state_t nxt_st;
   logic acc;
   logic wr;
   logic [9:0] idx;
   logic iso_eff;
   logic [PAYLOAD_W-1:0] cnt_inc;

   // register index match, used by read and write decode
   function automatic logic hit(input logic [9:0] a, input logic [9:0] k);
      hit = (a == k);
   endfunction : hit

   // control byte as software sees it in either view
   function automatic logic [7:0] ctrl_view(input utxch_state_t s,
                                            input logic host);
      logic [7:0] v;
      v = CTRL_RESET;
      v[BIT_AUTO_READY] = s.auto_ready;
      v[BIT_ISO] = host ? 1'b0 : s.iso;
      v[BIT_DIR] = s.dir;
      v[BIT_DMA_EN] = s.dma_en;
      v[BIT_DMA_MODE] = s.dma_mode;
      v[BIT_TOGGLE] = host ? s.toggle : 1'b0;
      ctrl_view = v;
   endfunction : ctrl_view

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   assign acc = I_WB_CYC & I_WB_STB;
   assign idx = I_WB_ADR[11:2];
   // write lands on the edge where ack is sampled high
   assign wr = acc & I_WB_WE & st_ff.ack & I_WB_SEL[0];
   assign iso_eff = st_ff.iso & ~I_HOST_MODE;
   assign cnt_inc = st_ff.cnt + COUNT_ONE;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.flush = 1'b0;
      nxt_st.done_evt = 1'b0;
      // one wait state, then ack for one cycle
      nxt_st.ack = acc & ~st_ff.ack;

      // sent packet: clear first so any set below wins
      if (I_TX_SENT) begin
         nxt_st.ready = 1'b0;
         nxt_st.done_evt = 1'b1;
         nxt_st.cnt = PAYLOAD_RESET;
      end
      // peer ack advances the toggle, iso traffic never does
      if (I_TX_ACK && !iso_eff) begin
         nxt_st.toggle = ~nxt_st.toggle;
      end
      // byte loads; a full payload raises ready when enabled
      if (I_FIFO_LOAD) begin
         if (st_ff.auto_ready && cnt_inc == st_ff.max_payload) begin
            nxt_st.ready = 1'b1;
            nxt_st.cnt = PAYLOAD_RESET;
         end else begin
            nxt_st.cnt = cnt_inc;
         end
      end

      // control byte write
      if (wr && hit(idx, IDX_CTRL_HIGH)) begin
         nxt_st.auto_ready = I_WB_DAT[BIT_AUTO_READY];
         if (!I_HOST_MODE) begin
            nxt_st.iso = I_WB_DAT[BIT_ISO];
         end
         nxt_st.dir = I_WB_DAT[BIT_DIR];
         nxt_st.dma_en = I_WB_DAT[BIT_DMA_EN];
         nxt_st.dma_mode = I_WB_DAT[BIT_DMA_MODE];
         // forced switch drops the packet whatever the handshake did
         if (I_WB_DAT[BIT_FORCE_TOGGLE]) begin
            nxt_st.toggle = ~st_ff.toggle;
            nxt_st.ready = 1'b0;
            nxt_st.flush = 1'b1;
            nxt_st.cnt = PAYLOAD_RESET;
         end
         // enable is armed and consumed by the same write
         if (I_HOST_MODE && I_WB_DAT[BIT_TOGGLE_WE]) begin
            nxt_st.toggle = I_WB_DAT[BIT_TOGGLE];
         end
      end
      // software ready set, used for short packets
      if (wr && hit(idx, IDX_STATUS) && I_WB_DAT[BIT_TX_READY]) begin
         nxt_st.ready = 1'b1;
      end
      // payload size; upper bits need the second lane
      if (wr && hit(idx, IDX_MAX_PAYLOAD)) begin
         nxt_st.max_payload[7:0] = I_WB_DAT[7:0];
         if (I_WB_SEL[1]) begin
            nxt_st.max_payload[PAYLOAD_W-1:8] = I_WB_DAT[PAYLOAD_W-1:8];
         end
      end

      // read data captured as ack rises; unmapped reads zero
      nxt_st.rdat = ZERO_WORD;
      if (acc && !st_ff.ack && !I_WB_WE) begin
         if (hit(idx, IDX_CTRL_HIGH)) begin
            nxt_st.rdat[7:0] = ctrl_view(st_ff, I_HOST_MODE);
         end else if (hit(idx, IDX_STATUS)) begin
            nxt_st.rdat[BIT_TX_READY] = st_ff.ready;
         end else if (hit(idx, IDX_MAX_PAYLOAD)) begin
            nxt_st.rdat[PAYLOAD_W-1:0] = st_ff.max_payload;
         end
      end

      // mode 0 asks only for a fresh packet, mode 1 while not ready
      nxt_st.dma_req = st_ff.dma_en & ~st_ff.ready &
                       (st_ff.dma_mode | (st_ff.cnt == PAYLOAD_RESET));
      // without a shared fifo the endpoint is always transmit
      nxt_st.dir_tx = I_SHARED_FIFO ? st_ff.dir : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register
   assign O_WB_ACK = st_ff.ack;
   assign O_WB_DAT = st_ff.rdat;
   assign O_TOGGLE = st_ff.toggle;
   assign O_TX_READY = st_ff.ready;
   assign O_FLUSH = st_ff.flush;
   assign O_TX_DONE_EVT = st_ff.done_evt;
   assign O_ISO = st_ff.iso;
   assign O_DIR_TX = st_ff.dir_tx;
   assign O_DMA_REQ_EN = st_ff.dma_en;
   assign O_DMA_MODE1 = st_ff.dma_mode;
   assign O_DMA_REQ = st_ff.dma_req;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_force_toggle;
      wr && hit(idx, IDX_CTRL_HIGH) && I_WB_DAT[BIT_FORCE_TOGGLE] &&
      !(I_HOST_MODE && I_WB_DAT[BIT_TOGGLE_WE]) |=>
         (O_TOGGLE != $past(O_TOGGLE)) && O_FLUSH && !O_TX_READY;
   endproperty
   a_force_toggle: assert property (p_force_toggle)
      else $error("forced toggle did not switch and drop packet");

   property p_toggle_load;
      wr && hit(idx, IDX_CTRL_HIGH) && I_HOST_MODE &&
      I_WB_DAT[BIT_TOGGLE_WE] |=> O_TOGGLE == $past(I_WB_DAT[BIT_TOGGLE]);
   endproperty
   a_toggle_load: assert property (p_toggle_load)
      else $error("enabled toggle write not loaded");

   property p_toggle_hold;
      wr && hit(idx, IDX_CTRL_HIGH) && !I_WB_DAT[BIT_TOGGLE_WE] &&
      !I_WB_DAT[BIT_FORCE_TOGGLE] && !I_TX_ACK |=>
         $stable(O_TOGGLE);
   endproperty
   a_toggle_hold: assert property (p_toggle_hold)
      else $error("toggle changed without write enable");

   property p_toggle_read;
      $rose(O_WB_ACK) && !$past(I_WB_WE) && $past(I_HOST_MODE) &&
      $past(hit(idx, IDX_CTRL_HIGH)) |->
         O_WB_DAT[BIT_TOGGLE] == $past(O_TOGGLE);
   endproperty
   a_toggle_read: assert property (p_toggle_read)
      else $error("toggle readback wrong");

   property p_reserved_zero;
      $rose(O_WB_ACK) && !$past(I_WB_WE) && !$past(I_HOST_MODE) &&
      $past(hit(idx, IDX_CTRL_HIGH)) |-> O_WB_DAT[1:0] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("device view low bits not zero");

   property p_auto_ready;
      st_ff.auto_ready && I_FIFO_LOAD && cnt_inc == st_ff.max_payload &&
      !(wr && hit(idx, IDX_CTRL_HIGH)) |=> O_TX_READY;
   endproperty
   a_auto_ready: assert property (p_auto_ready)
      else $error("full payload did not raise ready");

   property p_sent_clear;
      I_TX_SENT && !I_FIFO_LOAD && !wr |=> !O_TX_READY && O_TX_DONE_EVT;
   endproperty
   a_sent_clear: assert property (p_sent_clear)
      else $error("sent packet did not clear ready");

   property p_ack_toggle;
      I_TX_ACK && !iso_eff && !wr |=> O_TOGGLE != $past(O_TOGGLE);
   endproperty
   a_ack_toggle: assert property (p_ack_toggle)
      else $error("acked packet did not flip toggle");

   property p_dir_fixed;
      // sampled reset keeps the release edge, still reset state, out
      I_NRST && !I_SHARED_FIFO |=> O_DIR_TX;
   endproperty
   a_dir_fixed: assert property (p_dir_fixed)
      else $error("direction moved without shared fifo");

   property p_dma_gate;
      !O_DMA_REQ_EN |=> !O_DMA_REQ;
   endproperty
   a_dma_gate: assert property (p_dma_gate)
      else $error("dma request while disabled");

   property p_ack_pulse;
      O_WB_ACK |=> !O_WB_ACK;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_flush_pulse;
      O_FLUSH |=> !O_FLUSH;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse)
      else $error("flush held longer than one cycle");

   property p_done_pulse;
      !I_TX_SENT |=> !O_TX_DONE_EVT;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done event without a sent packet");

   property p_dma_mode;
      wr && hit(idx, IDX_CTRL_HIGH) |=>
         O_DMA_MODE1 == $past(I_WB_DAT[BIT_DMA_MODE]);
   endproperty
   a_dma_mode: assert property (p_dma_mode)
      else $error("dma mode bit not taken from write");

   property p_iso_host;
      wr && hit(idx, IDX_CTRL_HIGH) && I_HOST_MODE |=> $stable(O_ISO);
   endproperty
   a_iso_host: assert property (p_iso_host)
      else $error("iso bit changed by a host view write");

   // direction follows the written bit while the fifo stays shared
   property p_dir_write;
      wr && hit(idx, IDX_CTRL_HIGH) && I_SHARED_FIFO ##1 I_SHARED_FIFO |=>
         O_DIR_TX == $past(I_WB_DAT[BIT_DIR], 2);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction not taken from write");
endmodule : utxch_ctrl_high
`default_nettype wire

// ### hdl/utxch_pkg.sv
// constants for the transmit endpoint upper control byte block
// assumes a 32-bit classic wishbone slave port and a 100 MHz system clock
//
// Operation
// - force toggle flips toggle, drops packet
// - mode select bit picks dma mode one
// - toggle write enable arms, then self-clears
// - host view: toggle state bit reads live toggle
// - host view, enable high: written toggle value loads
// - enable low: toggle write ignored
// - auto ready on full payload load
// - device view: iso bit selects isochronous
// - direction bit: one transmit, zero receive
// - direction only matters with shared fifo
// - dma enable gates dma requests
// - device view low bits read zero
// - control byte resets to all zero
// - sent packet clears ready, raises event
package utxch_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL_HIGH = 10'h0113;
   localparam logic [9:0] IDX_STATUS = 10'h011C;
   localparam logic [9:0] IDX_MAX_PAYLOAD = 10'h011D;
   // control byte fields
   localparam int BIT_AUTO_READY = 7;
   localparam int BIT_ISO = 6;
   localparam int BIT_DIR = 5;
   localparam int BIT_DMA_EN = 4;
   localparam int BIT_FORCE_TOGGLE = 3;
   localparam int BIT_DMA_MODE = 2;
   localparam int BIT_TOGGLE_WE = 1;
   localparam int BIT_TOGGLE = 0;
   // status register field
   localparam int BIT_TX_READY = 0;
   // payload size field
   localparam int PAYLOAD_W = 11;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [PAYLOAD_W-1:0] PAYLOAD_RESET = 11'h000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [PAYLOAD_W-1:0] COUNT_ONE = 11'h001;
endpackage : utxch_pkg

// ### sim/utxch_peer.sv
// usb peer model: takes one queued packet per ready, may acknowledge it
// assumes i_ready is the endpoint packet-ready level, sampled on i_clk
`timescale 1ns/1ps
`default_nettype none
module utxch_peer (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // endpoint side and test knobs
   input wire logic i_ready,
   input wire logic [3:0] i_delay,
   input wire logic i_give_ack,
   // bus events back to the endpoint
   output logic o_sent,
   output logic o_ack
);
   // waits for ready to drop again so no packet is taken twice
   initial begin
      o_sent = 1'b0;
      o_ack = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_nrst && i_ready) begin
            repeat (i_delay) @(posedge i_clk);
            o_sent <= 1'b1;
            o_ack <= i_give_ack;
            @(posedge i_clk);
            o_sent <= 1'b0;
            o_ack <= 1'b0;
            while (i_ready) @(posedge i_clk);
         end
      end
   end
endmodule : utxch_peer
`default_nettype wire

// ### sim/utxch_ctrl_high_tb.sv
// self-checking bench for the transmit endpoint upper control byte
// assumes utxch_pkg, utxch_ctrl_high and utxch_peer compiled first
`timescale 1ns/1ps
`default_nettype none
module utxch_ctrl_high_tb;
   import utxch_pkg::*;
   localparam logic [11:0] A_CTRL = {IDX_CTRL_HIGH, 2'b00};
   localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};
   localparam logic [11:0] A_PAY = {IDX_MAX_PAYLOAD, 2'b00};
   logic clk, nrst, cyc, stb, we, hmode, shared, load, dack, ack;
   logic tog, rdy, flush, done, iso, dir, den, dm1, dreq, sent, pack;
   logic [11:0] adr;
   logic [31:0] wdat, rdat, q;
   logic [3:0] dly;
   int bad_count = 0, cmp_count = 0, flush_n = 0, done_n = 0;
   utxch_ctrl_high uut (.I_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc),
      .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
      .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
      .I_HOST_MODE(hmode), .I_SHARED_FIFO(shared), .I_FIFO_LOAD(load),
      .I_TX_SENT(sent), .I_TX_ACK(pack), .O_TOGGLE(tog), .O_TX_READY(rdy),
      .O_FLUSH(flush), .O_TX_DONE_EVT(done), .O_ISO(iso), .O_DIR_TX(dir),
      .O_DMA_REQ_EN(den), .O_DMA_MODE1(dm1), .O_DMA_REQ(dreq));
   utxch_peer peer (.i_clk(clk), .i_nrst(nrst), .i_ready(rdy),
      .i_delay(dly), .i_give_ack(dack), .o_sent(sent), .o_ack(pack));
   ////////////////////////////////////////////////////////////////////////
   // clock and one-cycle pulse counters
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (flush === 1'b1) flush_n++;
      if (done === 1'b1) done_n++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // classic single cycle; data taken at the edge that samples ack
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, ZERO_WORD);
      chk(q, exp);
   endtask : rd_chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // back-to-back fifo byte loads
   task automatic push(input int n);
      @(posedge clk);
      load <= 1'b1;
      repeat (n) @(posedge clk);
      load <= 1'b0;
   endtask : push
   ////////////////////////////////////////////////////////////////////////
   task automatic t_toggle;
      bus(1'b1, A_CTRL, 32'h0000_0003);
      tick(2);
      chk(tog, 1'b1);
      rd_chk(A_CTRL, 32'h0000_0001);
      bus(1'b1, A_CTRL, ZERO_WORD);
      tick(2);
      chk(tog, 1'b1);
      flush_n = 0;
      bus(1'b1, A_CTRL, 32'h0000_0008);
      tick(3);
      chk(tog, 1'b0);
      chk(flush_n, 1);
   endtask : t_toggle
   // enable is dropped before the mode bit, never with it
   task automatic t_dma;
      bus(1'b1, A_CTRL, 32'h0000_0014);
      tick(2);
      chk({den, dm1, dreq}, 3'b111);
      bus(1'b1, A_CTRL, 32'h0000_0004);
      tick(2);
      chk({den, dm1, dreq}, 3'b010);
      bus(1'b1, A_CTRL, ZERO_WORD);
      tick(2);
      chk(dm1, 1'b0);
   endtask : t_dma
   task automatic t_dir;
      shared <= 1'b1;
      bus(1'b1, A_CTRL, 32'h0000_0020);
      tick(2);
      chk(dir, 1'b1);
      bus(1'b1, A_CTRL, ZERO_WORD);
      tick(2);
      chk(dir, 1'b0);
      shared <= 1'b0;
      tick(2);
      chk(dir, 1'b1);
   endtask : t_dir
   // full payload with auto ready; slow peer lets ready be seen high
   // exp: toggle after the packet, from the rules (ack flips, iso holds)
   task automatic t_auto(input logic [31:0] c, input logic [3:0] d,
         input logic exp);
      dly <= d;
      done_n = 0;
      bus(1'b1, A_CTRL, c);
      push(2);
      tick(2);
      if (d > 4'h2) chk(rdy, 1'b1);
      tick(14);
      chk({rdy, tog}, {1'b0, exp});
      chk(done_n, 1);
   endtask : t_auto
   // short packet: no auto ready, software sets it (never auto on hb eps)
   task automatic t_short;
      dly <= 4'h6;
      push(1);
      tick(3);
      chk(rdy, 1'b0);
      bus(1'b1, A_STAT, 32'h0000_0001);
      tick(2);
      chk(rdy, 1'b1);
      tick(14);
      chk(rdy, 1'b0);
   endtask : t_short
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #400us;
      bad_count++;
      finish_test;
   end
   initial begin
      {nrst, cyc, stb, we, load, shared} = '0;
      {adr, wdat} = '0;
      hmode = 1'b1;
      dack = 1'b1;
      dly = 4'h3;
      tick(2);
      nrst <= 1'b1;
      tick(2);
      chk(dir, 1'b1);
      rd_chk(A_CTRL, {24'h0, CTRL_RESET});
      t_toggle;
      t_dma;
      t_dir;
      hmode <= 1'b0;
      bus(1'b1, A_CTRL, 32'h0000_00C3);
      rd_chk(A_CTRL, 32'h0000_00C0);
      chk({iso, tog}, 2'b10);
      bus(1'b1, A_PAY, 32'h0000_0002);
      t_auto(32'h0000_0080, 4'h8, 1'b1);
      t_auto(32'h0000_00C0, 4'h0, 1'b1);
      t_short;
      bus(1'b1, 12'h400, 32'hFFFF_FFFF);
      rd_chk(12'h400, ZERO_WORD);
      finish_test;
   end
endmodule : utxch_ctrl_high_tb
`default_nettype wire
